// >>> core/scp_pkg.sv
// Package for the system clock select and prescaler block.
// Assumes a 125 MHz undivided source clock on clk_sys.
package scp_pkg;

  // ************************************************************
  // Register map (byte addresses, one word each)
  // ************************************************************
  localparam int          AW            = 4;
  localparam logic [3:0]  OFS_TRIM      = 4'h0;
  localparam logic [3:0]  OFS_DIVIDE    = 4'h4;
  localparam logic [3:0]  OFS_STATUS    = 4'h8;

  // ************************************************************
  // Field layout and reset values
  // ************************************************************
  localparam int          UNLOCK_BIT    = 7;
  localparam logic [6:0]  DIV_OTHER_0   = 7'h00;
  localparam logic [3:0]  DIV_RST_NORM  = 4'h0;
  localparam logic [3:0]  DIV_RST_DIV8  = 4'h3;
  localparam logic [3:0]  DIV_MAX_CODE  = 4'h8;
  localparam logic [2:0]  UNLOCK_CYC    = 3'h4;

  // Clock source fuse codes
  localparam logic [3:0]  CLOCK_SOURCE_SELECT_FUSES_EXT0    = 4'h0;
  localparam logic [3:0]  CLOCK_SOURCE_SELECT_FUSES_EXT1    = 4'h1;
  localparam logic [3:0]  CLOCK_SOURCE_SELECT_FUSES_LP      = 4'h6;

  // Start-up fuse codes
  localparam logic [1:0]  SUT_SHORT     = 2'h0;
  localparam logic [1:0]  SUT_FAST      = 2'h1;
  localparam logic [1:0]  SUT_SLOW      = 2'h2;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam real         CLK_MHZ       = 125.0;
  localparam int          BASE_CK       = 14;
  localparam real         EXT_FAST_MS   = 4.1;
  localparam real         EXT_SLOW_MS   = 65.0;
  localparam real         LP_FAST_MS    = 4.0;
  localparam real         LP_SLOW_MS    = 64.0;
  localparam int          EXT_FAST_CYC  = int'($ceil(EXT_FAST_MS * CLK_MHZ * 1000.0));
  localparam int          EXT_SLOW_CYC  = int'($ceil(EXT_SLOW_MS * CLK_MHZ * 1000.0));
  localparam int          LP_FAST_CYC   = int'($ceil(LP_FAST_MS * CLK_MHZ * 1000.0));
  localparam int          LP_SLOW_CYC   = int'($ceil(LP_SLOW_MS * CLK_MHZ * 1000.0));
  localparam int          DLY_W         = 24;

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [1:0] {
    SRC_NONE = 2'b00,
    SRC_EXT  = 2'b01,
    SRC_LP   = 2'b10
  } scp_src_t;

  typedef struct packed {
    logic       rst_pin_dis;
    logic       div8;
    logic [1:0] startup_time_fuses;
    logic [3:0] clock_source_select_fuses;
  } scp_fuse_t;

  typedef struct packed {
    logic          read;
    logic          write;
    logic [AW-1:0] address;
    logic [3:0]    byteenable;
    logic [31:0]   writedata;
  } scp_av_req_t;

endpackage : scp_pkg

// >>> core/scp_clock_ctrl.sv
// Clock source select, reset start-up delay, trim register and
// glitch-free power-of-two prescaler behind an Avalon-MM slave.
// Assumes fuses and factory trim are static straps from outside
// the clk_sys domain; clk_sys is the undivided source clock.
`timescale 1ns/100ps

// Notes on behaviour
// - trim register loads factory byte during reset
// - trim zero slowest, 0x7f fastest, monotonic
// - trim span is analog, code passed through
// - source code 0000/0001 selects external clock
// - external clock reset delay from start-up code
// - source code 0110 selects low-power oscillator
// - low-power oscillator reset delay from start-up code
// - reset-pin-disable lengthens shortest delay by 4 ms
// - one prescaler tick feeds io, cpu, flash
// - no tick spacing shorter than old or new
// - new factor starts within one old period
// - prescaler counts source clock, not readable
// - unlock write then division write within four
// - unlock changes only with other bits zero
// - unlock clears after four cycles or division write
// - reset division is 0 or 3 from fuse
// - any division code accepted regardless of fuse
// - division factor is two to the code, 256 for codes 8 and above
module scp_clock_ctrl #(
  parameter int EXT_FAST_CYC = scp_pkg::EXT_FAST_CYC,
  parameter int EXT_SLOW_CYC = scp_pkg::EXT_SLOW_CYC,
  parameter int LP_FAST_CYC  = scp_pkg::LP_FAST_CYC,
  parameter int LP_SLOW_CYC  = scp_pkg::LP_SLOW_CYC
) (
  input  wire  logic                clk_sys,
  input  wire  logic                sys_rst,
  input  wire  scp_pkg::scp_av_req_t av_req,
  output logic                      av_waitrequest,
  output logic [31:0]               av_readdata,
  input  wire  scp_pkg::scp_fuse_t  fuse_in,
  input  wire  logic [6:0]          factory_trim,
  output logic [6:0]                trim_value,
  output scp_pkg::scp_src_t         clock_source_sel,
  output logic                      sut_reserved,
  output logic                      sys_ready,
  output logic                      io_clock_en,
  output logic                      cpu_clock_en,
  output logic                      flash_clock_en
);
  import scp_pkg::*;

  // ************************************************************
  // Strap synchroniser and capture
  // ************************************************************
  localparam int SW = 15;

  logic [SW-1:0] strap_s1_q;
  logic [SW-1:0] strap_s2_q;
  logic [SW-1:0] strap_s3_q;
  scp_fuse_t     fuse_q;
  wire           strap_agree = (strap_s2_q == strap_s3_q);
  wire           strap_take  = sys_rst && strap_agree;
  scp_fuse_t     strap_fuse;
  wire  [6:0]    strap_trim  = strap_s3_q[6:0];

  assign strap_fuse = strap_s3_q[SW-1:7];

  always_ff @(posedge clk_sys) begin
    strap_s1_q <= {fuse_in, factory_trim};
    strap_s2_q <= strap_s1_q;
    strap_s3_q <= strap_s2_q;
  end

  // Held constant once reset is released
  always_ff @(posedge clk_sys) begin
    if (strap_take) begin
      fuse_q <= strap_fuse;
    end
  end

  // ************************************************************
  // Avalon-MM decode
  // ************************************************************
  logic rd_ack_q;

  wire hit_trim   = (av_req.address == OFS_TRIM);
  wire hit_div    = (av_req.address == OFS_DIVIDE);
  wire hit_stat   = (av_req.address == OFS_STATUS);
  wire wr_lane0   = av_req.write && av_req.byteenable[0];
  wire wr_trim    = wr_lane0 && hit_trim;
  wire wr_div     = wr_lane0 && hit_div;
  wire wd_unlock  = av_req.writedata[UNLOCK_BIT];
  wire wd_other0  = (av_req.writedata[6:0] == DIV_OTHER_0);
  wire rd_fire    = av_req.read && !rd_ack_q;

  // One wait state on reads so read data comes from a flop
  assign av_waitrequest = av_req.read && !rd_ack_q;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rd_ack_q <= 1'b0;
    end else begin
      rd_ack_q <= rd_fire;
    end
  end

  // ************************************************************
  // Trim register
  // ************************************************************
  logic [6:0] trim_q;

  always_ff @(posedge clk_sys) begin
    if (strap_take) begin
      trim_q <= strap_trim;
    end else if (!sys_rst && wr_trim) begin
      trim_q <= av_req.writedata[6:0];
    end
  end

  // Code drives the oscillator directly, larger is faster
  assign trim_value = trim_q;

  // ************************************************************
  // Division register and unlock window
  // ************************************************************
  logic [2:0] unlock_cnt_q;
  logic [3:0] div_sel_q;
  wire        unlock      = (unlock_cnt_q != 3'h0);
  wire        unlock_wr   = wr_div && wd_unlock && wd_other0;
  wire        div_accept  = wr_div && !wd_unlock && unlock;
  wire [3:0]  div_rst_val = fuse_q.div8 ? DIV_RST_DIV8 : DIV_RST_NORM;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      unlock_cnt_q <= 3'h0;
    end else if (div_accept) begin
      unlock_cnt_q <= 3'h0;
    end else if (unlock_wr && !unlock) begin
      unlock_cnt_q <= UNLOCK_CYC;
    end else if (unlock) begin
      unlock_cnt_q <= unlock_cnt_q - 3'h1;
    end
  end

  // Reset value follows the capture made just before release
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      div_sel_q <= strap_take ? (strap_fuse.div8 ? DIV_RST_DIV8 : DIV_RST_NORM)
                              : div_rst_val;
    end else if (div_accept) begin
      div_sel_q <= av_req.writedata[3:0];
    end
  end

  // ************************************************************
  // Prescaler
  // ************************************************************
  // Counts undivided cycles; never mapped to a register.
  logic [7:0] pre_cnt_q;
  logic [3:0] div_act_q;
  logic       tick_q;
  wire  [7:0] act_mask  = 8'((9'h1 << div_act_q) - 9'h1);
  wire        pre_wrap  = ((pre_cnt_q & act_mask) == act_mask);

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pre_cnt_q <= 8'h00;
      div_act_q <= DIV_RST_NORM;
      tick_q    <= 1'b0;
    end else begin
      tick_q <= pre_wrap;
      if (pre_wrap) begin
        pre_cnt_q <= 8'h00;
        div_act_q <= div_sel_q;
      end else begin
        pre_cnt_q <= pre_cnt_q + 8'h01;
      end
    end
  end

  // Same enable for every synchronous domain
  assign io_clock_en    = tick_q;
  assign cpu_clock_en   = tick_q;
  assign flash_clock_en = tick_q;

  // ************************************************************
  // Source select and reset delay
  // ************************************************************
  typedef enum logic [1:0] {
    ST_RESET = 2'b00,
    ST_DELAY = 2'b01,
    ST_RUN   = 2'b10
  } scp_state_t;

  scp_state_t       state_q;
  logic [DLY_W-1:0] dly_cnt_q;
  logic [DLY_W-1:0] dly_extra;

  wire is_ext = (fuse_q.clock_source_select_fuses == CLOCK_SOURCE_SELECT_FUSES_EXT0) || (fuse_q.clock_source_select_fuses == CLOCK_SOURCE_SELECT_FUSES_EXT1);
  wire is_lp  = (fuse_q.clock_source_select_fuses == CLOCK_SOURCE_SELECT_FUSES_LP);

  assign clock_source_sel = is_ext ? SRC_EXT : (is_lp ? SRC_LP : SRC_NONE);
  assign sut_reserved     = (fuse_q.startup_time_fuses == 2'h3);

  // Reserved start-up code falls back to the shortest delay
  always_comb begin
    dly_extra = '0;
    unique case (fuse_q.startup_time_fuses)
      SUT_FAST: begin
        dly_extra = is_lp ? DLY_W'(LP_FAST_CYC) : DLY_W'(EXT_FAST_CYC);
      end
      SUT_SLOW: begin
        dly_extra = is_lp ? DLY_W'(LP_SLOW_CYC) : DLY_W'(EXT_SLOW_CYC);
      end
      default: begin
        if (fuse_q.rst_pin_dis) begin
          dly_extra = DLY_W'(LP_FAST_CYC);
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_q   <= ST_RESET;
      dly_cnt_q <= '0;
    end else begin
      unique case (state_q)
        ST_RESET: begin
          state_q   <= ST_DELAY;
          dly_cnt_q <= dly_extra + DLY_W'(BASE_CK - 1);
        end
        ST_DELAY: begin
          if (dly_cnt_q == '0) begin
            state_q <= ST_RUN;
          end else begin
            dly_cnt_q <= dly_cnt_q - DLY_W'(1);
          end
        end
        ST_RUN: begin
          state_q <= ST_RUN;
        end
        default: begin
          state_q <= ST_RESET;
        end
      endcase
    end
  end

  assign sys_ready = (state_q == ST_RUN);

  // ************************************************************
  // Read data
  // ************************************************************
  wire [31:0] rd_trim = {25'h0, trim_q};
  wire [31:0] rd_div  = {24'h0, unlock, 3'h0, div_sel_q};
  wire [31:0] rd_stat = {22'h0, sut_reserved, sys_ready, 8'(fuse_q)};
  wire [31:0] rd_mux  = hit_trim ? rd_trim :
                        hit_div  ? rd_div  :
                        hit_stat ? rd_stat : 32'h0;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      av_readdata <= 32'h0;
    end else if (rd_fire) begin
      av_readdata <= rd_mux;
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  logic [8:0] gap_q;

  always_ff @(posedge clk_sys) begin
    if (sys_rst || pre_wrap) begin
      gap_q <= 9'h0;
    end else begin
      gap_q <= gap_q + 9'h1;
    end
  end

  AST_TRIM_RESET: assert property (@(posedge clk_sys)
    strap_take |=> trim_q == $past(strap_trim))
    else $error("trim not loaded from factory byte in reset");

  // An accepted division closes the window early, so only the far end is pinned
  AST_UNLOCK_TIMEOUT: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $rose(unlock) |-> ##4 (!unlock || $rose(unlock)))
    else $error("unlock window longer than four cycles");

  AST_UNLOCK_REWRITE: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (unlock_wr && unlock_cnt_q > 3'h1) |=> unlock_cnt_q == $past(unlock_cnt_q) - 3'h1)
    else $error("unlock rewrite changed the window");

  AST_UNLOCK_ONLY_CLEAN: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (wr_div && wd_unlock && !wd_other0 && !unlock) |=> !unlock && $stable(div_sel_q))
    else $error("unlock set by write with other bits");

  AST_DIV_ACCEPT: assert property (@(posedge clk_sys) disable iff (sys_rst)
    div_accept |=> div_sel_q == $past(av_req.writedata[3:0]) && !unlock)
    else $error("division write in window not taken");

  AST_DIV_LOCKED: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (wr_div && !wd_unlock && !unlock) |=> $stable(div_sel_q))
    else $error("division changed without unlock");

  AST_DIV8_RESET: assert property (@(posedge clk_sys)
    ($past(sys_rst) && !sys_rst) |-> div_sel_q == (fuse_q.div8 ? DIV_RST_DIV8 : DIV_RST_NORM))
    else $error("reset division does not follow fuse");

  AST_TICK_SPACING: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (pre_wrap && div_act_q <= DIV_MAX_CODE && $past(pre_wrap, 1) == 1'b0 && gap_q != 9'h0)
      |-> (gap_q + 9'h1) == (9'h1 << div_act_q))
    else $error("tick spacing differs from active factor");

  AST_CHANGE_LATENCY: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (div_accept && av_req.writedata[3:0] <= DIV_MAX_CODE)
      |=> ##[0:256] (div_act_q == div_sel_q))
    else $error("new division not active within one old period");

  AST_DELAY_HOLD: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (state_q == ST_DELAY && dly_cnt_q != '0) |=> !sys_ready)
    else $error("ready before start-up delay ended");

  AST_READY_STAYS: assert property (@(posedge clk_sys) disable iff (sys_rst)
    sys_ready |=> sys_ready)
    else $error("ready dropped while running");

  // ************************************************************
  // Strap and register checks
  // ************************************************************
  // The capture edge itself is excluded; only later drift is a fault
  AST_FUSE_HOLD: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !$past(sys_rst) |-> $stable(fuse_q))
    else $error("captured fuses changed while running");

  AST_SRC_EXT_ONLY: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (clock_source_sel == SRC_EXT) |-> fuse_q.clock_source_select_fuses[3:1] == 3'h0)
    else $error("external source chosen for another code");

  AST_SRC_LP_ONLY: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (clock_source_sel == SRC_LP) |-> fuse_q.clock_source_select_fuses == CLOCK_SOURCE_SELECT_FUSES_LP)
    else $error("low-power source chosen for another code");

  AST_TRIM_WRITE: assert property (@(posedge clk_sys) disable iff (sys_rst)
    wr_trim |=> trim_value == $past(av_req.writedata[6:0]))
    else $error("trim write not passed to the oscillator");

  // Reads and writes never overlap, so the loaded word cannot go stale
  AST_READ_TRIM: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (av_req.read && !av_waitrequest && hit_trim) |-> av_readdata == {25'h0, trim_q})
    else $error("trim read back differs from register");

  AST_READ_ONE_WAIT: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (av_req.read && av_waitrequest) |=> !av_waitrequest)
    else $error("read held for more than one wait state");

  // ************************************************************
  // Prescaler checks
  // ************************************************************
  // Factor may only move on a tick boundary, else a short pulse appears
  AST_DIV_STEADY: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !pre_wrap |=> $stable(div_act_q))
    else $error("active factor changed inside a period");

  AST_TICK_ONE: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (io_clock_en && div_act_q != 4'h0) |=> !io_clock_en)
    else $error("back to back ticks above factor one");

endmodule : scp_clock_ctrl

// >>> verification/scp_clock_ctrl_tb.sv
// Self-checking bench for the clock select and prescaler block.
// Assumes scp_pkg and scp_clock_ctrl are compiled first; start-up counts shortened.
`timescale 1ns/100ps
module scp_clock_ctrl_tb;
  import scp_pkg::*;
  // ************************************************************
  // Setup
  // ************************************************************
  localparam int EF = 20;
  localparam int ES = 40;
  localparam int LF = 16;
  localparam int LS = 32;
  logic        clk_sys          = 1'b0;
  logic        sys_rst          = 1'b1;
  scp_av_req_t av_req           = '0;
  scp_fuse_t   fuse_in          = 8'h56;
  logic [6:0]  factory_trim     = 7'h00;
  logic        av_waitrequest;
  logic [31:0] av_readdata;
  logic [6:0]  trim_value;
  scp_src_t    clock_source_sel;
  logic        sut_reserved;
  logic        sys_ready;
  logic        io_clock_en;
  logic        cpu_clock_en;
  logic        flash_clock_en;
  int          miscompares      = 0;
  int          n_checks         = 0;
  int          since            = 0;
  int          minsp            = 999;
  int          nticks           = 0;
  logic        mon_on           = 1'b0;
  int          n;
  scp_fuse_t   cfg [7]  = '{8'h20, 8'h11, 8'h26, 8'h80, 8'h06, 8'h36, 8'h56};
  scp_src_t    srcs [7] = '{SRC_EXT, SRC_EXT, SRC_LP, SRC_EXT, SRC_LP, SRC_LP, SRC_LP};
  int          xtra [7] = '{ES, EF, LS, LF, 0, 0, LF};

  scp_clock_ctrl #(.EXT_FAST_CYC(EF), .EXT_SLOW_CYC(ES), .LP_FAST_CYC(LF), .LP_SLOW_CYC(LS))
    i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .av_req(av_req),
           .av_waitrequest(av_waitrequest), .av_readdata(av_readdata), .fuse_in(fuse_in),
           .factory_trim(factory_trim), .trim_value(trim_value),
           .clock_source_sel(clock_source_sel), .sut_reserved(sut_reserved),
           .sys_ready(sys_ready), .io_clock_en(io_clock_en), .cpu_clock_en(cpu_clock_en),
           .flash_clock_en(flash_clock_en));

  // Fixed period, so the source never jumps outside reset
  always #4 clk_sys = ~clk_sys;

  // ************************************************************
  // Tasks
  // ************************************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic end_sim;
    if (miscompares == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_sim

  // Request held until waitrequest is sampled low, then one idle edge
  task automatic bus(input logic r, input logic [AW-1:0] a, input logic [31:0] d,
                     input logic [3:0] be, output logic [31:0] q);
    av_req <= '{read: r, write: ~r, address: a, byteenable: be, writedata: d};
    do begin
      @(posedge clk_sys);
    end while (av_waitrequest !== 1'b0);
    q = av_readdata;
    av_req <= '0;
    @(posedge clk_sys);
  endtask : bus

  task automatic wr(input logic [AW-1:0] a, input logic [31:0] d, input logic [3:0] be = 4'hf);
    logic [31:0] q;
    bus(1'b0, a, d, be, q);
  endtask : wr

  task automatic rdchk(input logic [AW-1:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b1, a, 32'h0, 4'hf, q);
    chk(q, exp);
  endtask : rdchk

  task automatic idle(input int c);
    repeat (c) @(posedge clk_sys);
  endtask : idle

  // Software walks the trim in small steps only
  task automatic trim_to(input logic [6:0] t);
    logic [6:0] c;
    c = trim_value;
    while (c != t) begin
      if (t > c) c = (t - c > 7'h20) ? c + 7'h20 : t;
      else c = (c - t > 7'h20) ? c - 7'h20 : t;
      wr(OFS_TRIM, {25'h0, c});
    end
  endtask : trim_to

  task automatic gap(output int g);
    g = 0;
    do begin
      @(posedge clk_sys);
      g++;
    end while (io_clock_en !== 1'b1 && g < 600);
  endtask : gap

  task automatic setdiv(input logic [3:0] c);
    int g;
    // Nothing may run between the two writes
    wr(OFS_DIVIDE, 32'h80);
    wr(OFS_DIVIDE, {28'h0, c});
    repeat (3) gap(g);
  endtask : setdiv

  // Counts ticks and the shortest spacing right after a division change
  task automatic xfer(input int o, input int w);
    setdiv(o[3:0]);
    wr(OFS_DIVIDE, 32'h80);
    minsp = 999;
    nticks = 0;
    wr(OFS_DIVIDE, w);
    mon_on <= 1'b1;
    idle((1 << o) + 2 * (1 << w) - 1);
    @(negedge clk_sys);
    mon_on = 1'b0;
    chk(nticks >= 2, 1);
    chk(minsp >= ((o < w) ? (1 << o) : (1 << w)), 1);
  endtask : xfer

  // The three enables must always be the same pulse
  always @(posedge clk_sys) begin
    since++;
    if (io_clock_en === 1'b1) begin
      if (cpu_clock_en !== 1'b1 || flash_clock_en !== 1'b1) chk(0, 1);
      if (mon_on && since < minsp) minsp = since;
      if (mon_on) nticks++;
      since = 0;
    end
  end

  initial begin
    repeat (30000) @(posedge clk_sys);
    miscompares++;
    end_sim;
  end

  // ************************************************************
  // Tests
  // ************************************************************
  initial begin
    for (int i = 0; i < 7; i++) begin
      fuse_in <= cfg[i];
      factory_trim <= 7'h10 + i;
      sys_rst <= 1'b1;
      idle(12);
      sys_rst <= 1'b0;
      n = 0;
      do begin
        @(posedge clk_sys);
        n++;
      end while (sys_ready !== 1'b1 && n < 200);
      chk(n >= 14 + xtra[i] && n <= 17 + xtra[i], 1);
      chk(clock_source_sel, srcs[i]);
      chk(trim_value, 7'h10 + i);
      chk(sut_reserved, cfg[i].startup_time_fuses == 2'h3);
      rdchk(OFS_DIVIDE, cfg[i].div8 ? 32'h3 : 32'h0);
      rdchk(OFS_STATUS, {22'h0, cfg[i].startup_time_fuses == 2'h3, 1'b1, cfg[i]});
    end
    fuse_in <= 8'h20;
    idle(4);
    chk(clock_source_sel, SRC_LP);
    rdchk(OFS_STATUS, 32'h156);
    // No nonvolatile write runs here, so the top code is allowed
    trim_to(7'h7f);
    wr(OFS_TRIM, 32'hff);
    rdchk(OFS_TRIM, 32'h7f);
    chk(trim_value, 7'h7f);
    wr(OFS_TRIM, 32'h55, 4'h0);
    rdchk(OFS_TRIM, 32'h7f);
    trim_to(7'h00);
    chk(trim_value, 7'h00);
    wr(4'hc, 32'hffff_ffff);
    rdchk(4'hc, 32'h0);
    wr(OFS_DIVIDE, 32'h81);
    rdchk(OFS_DIVIDE, 32'h3);
    wr(OFS_DIVIDE, 32'h02);
    rdchk(OFS_DIVIDE, 32'h3);
    wr(OFS_DIVIDE, 32'h80);
    rdchk(OFS_DIVIDE, 32'h83);
    wr(OFS_DIVIDE, 32'h02);
    rdchk(OFS_DIVIDE, 32'h3);
    wr(OFS_DIVIDE, 32'h80);
    wr(OFS_DIVIDE, 32'h80);
    idle(1);
    wr(OFS_DIVIDE, 32'h02);
    rdchk(OFS_DIVIDE, 32'h3);
    wr(OFS_DIVIDE, 32'h80);
    idle(2);
    wr(OFS_DIVIDE, 32'h05);
    rdchk(OFS_DIVIDE, 32'h5);
    wr(OFS_DIVIDE, 32'h80);
    idle(3);
    wr(OFS_DIVIDE, 32'h06);
    rdchk(OFS_DIVIDE, 32'h5);
    for (int c = 0; c <= 8; c++) begin
      setdiv(c[3:0]);
      gap(n);
      chk(n, 1 << c);
    end
    xfer(3, 1);
    xfer(1, 3);
    xfer(8, 0);
    xfer(0, 8);
    end_sim;
  end
endmodule : scp_clock_ctrl_tb
